// ==== hdl/omc_macrocell.v ====
// one output macrocell: mode decode, polarity, output register, feedback select
`timescale 1ns/100ps
`default_nettype none
module omc_macrocell (
  input wire clock_i,
  input wire nrst_i,
  input wire sync_mode_select_i,
  input wire arch_ctrl_global_i,
  input wire arch_ctrl_per_cell_i,
  input wire pol_i,
  input wire sum_i,
  input wire pterm_oe_i,
  input wire shared_oe_i,
  input wire clk_en_i,
  input wire preload_i,
  input wire shift_en_i,
  input wire chain_i,
  input wire pin_i,
  output wire q_o,
  output wire registered_o,
  output wire drive_o,
  output wire oe_o,
  output wire feedback_o
);
  reg q_q;
  wire reg_mode;
  wire comb_pt;
  wire comb_on;

  // invalid codes fall through to output off, same as the input-only mode
  assign reg_mode = ~sync_mode_select_i & arch_ctrl_global_i &
                    ~arch_ctrl_per_cell_i;
  assign comb_pt = arch_ctrl_global_i & arch_ctrl_per_cell_i;
  assign comb_on = sync_mode_select_i & ~arch_ctrl_global_i &
                   ~arch_ctrl_per_cell_i;
  assign registered_o = reg_mode;
  // output off in the input-only code (sync 1, global 0, cell 1)
  assign oe_o = reg_mode ? shared_oe_i : (comb_pt ? pterm_oe_i : comb_on);
  // the register holds the inverted pin value, so a cleared register drives high
  assign drive_o = reg_mode ? ~q_q : (sum_i ^ ~pol_i);
  assign feedback_o = reg_mode ? q_q : pin_i;
  assign q_o = q_q;

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_q <= 1'b0;
    end else if (reg_mode) begin
      if (preload_i) begin
        if (shift_en_i) begin
          q_q <= chain_i;
        end
      end else if (clk_en_i) begin
        q_q <= sum_i ^ pol_i;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/omc_regs.vh ====
// constants for the configurable output macrocell block
`ifndef OMC_REGS_VH
`define OMC_REGS_VH

`define OMC_CELLS 8
`define OMC_ADDR_W 11
`define OMC_CSR_BIT 10
`define OMC_ROW_HI 9
`define OMC_ROW_LO 4
`define OMC_WSEL_HI 3
`define OMC_WSEL_LO 2

`define OMC_ROW_SIG 6'h20
`define OMC_ROW_RSV_LAST 6'h3B
`define OMC_ROW_ARCH 6'h3C
`define OMC_ROW_SEC 6'h3D
`define OMC_ROW_ERASE 6'h3F

`define OMC_CTRL_WSEL 2'h0
`define OMC_STATUS_WSEL 2'h1
`define OMC_CTRL_PROG_EN 0

`define OMC_ST_SEC 0
`define OMC_ST_BUSY 1
`define OMC_ST_PRELOAD 2
`define OMC_ST_SYNC_MODE 3
`define OMC_ST_REG_LO 8
`define OMC_ST_Q_LO 16

`define OMC_ARCH_W 82
`define OMC_ARCH_POL_LO 0
`define OMC_ARCH_CELL_LO 8
`define OMC_ARCH_GLOBAL 16
`define OMC_ARCH_SYNC_MODE 17
`define OMC_ARCH_RST 82'h0
`define OMC_SIG_RST 64'h0

`define OMC_MEM_AW 6
`define OMC_MEM_LAST 6'h3F
`define OMC_RD_READY 2'h2

`endif

// ==== hdl/omc_row_mem.v ====
// array row storage: 64 words of 32 bits, byte-lane writes, registered read
`timescale 1ns/100ps
`default_nettype none
module omc_row_mem (
  input wire clock_i,
  input wire [5:0] addr_i,
  input wire [3:0] we_i,
  input wire [31:0] wdata_i,
  output reg [31:0] rdata_o
);
  reg [31:0] mem_q [0:63];
  integer b;

  // one process owns the array, so every lane write has a single driver
  always @(posedge clock_i) begin
    for (b = 0; b < 4; b = b + 1) begin
      if (we_i[b]) begin
        mem_q[addr_i][8*b+:8] <= wdata_i[8*b+:8];
      end
    end
  end

  always @(posedge clock_i) begin
    rdata_o <= mem_q[addr_i];
  end
endmodule
`default_nettype wire

// ==== hdl/omc_top.v ====
// configurable output stage: row map behind Avalon-MM, eight macrocells, preload chain
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/100ps
`include "omc_regs.vh"
`default_nettype none
module omc_top (
  input wire clock_i,
  input wire nrst_i,
  input wire [10:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  input wire array_clock_pin_i,
  input wire shared_oe_n_pin_i,
  output wire clock_pin_data_o,
  output wire oe_pin_data_o,
  input wire [7:0] sum_term_i,
  input wire [7:0] pterm_oe_i,
  output wire [7:0] feedback_o,
  input wire [7:0] io_in_i,
  output wire [7:0] io_out_o,
  output wire [7:0] io_oe_o,
  input wire preload_enable_pin_i,
  input wire serial_preload_in_i,
  input wire preload_shift_clock_i,
  output wire serial_preload_out_o,
  output wire serial_preload_out_oe_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [12:0] sync1_q;
  reg [12:0] sync2_q;
  reg clk_prev_q;
  reg shift_clock_prev_q;
  wire [7:0] s_io;
  wire s_array_clock;
  wire s_oe_n;
  wire s_preload_pin;
  wire s_serial_in;
  wire s_shift_clock;

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_q <= 13'h0000;
      sync2_q <= 13'h0000;
      clk_prev_q <= 1'b0;
      shift_clock_prev_q <= 1'b0;
    end else begin
      sync1_q <= {preload_shift_clock_i, serial_preload_in_i, preload_enable_pin_i,
                  shared_oe_n_pin_i, array_clock_pin_i, io_in_i};
      sync2_q <= sync1_q;
      clk_prev_q <= sync2_q[8];
      shift_clock_prev_q <= sync2_q[12];
    end
  end

  assign s_io = sync2_q[7:0];
  assign s_array_clock = sync2_q[8];
  assign s_oe_n = sync2_q[9];
  assign s_preload_pin = sync2_q[10];
  assign s_serial_in = sync2_q[11];
  assign s_shift_clock = sync2_q[12];

  // ---------------------------------------------------------------
  // configuration state
  // ---------------------------------------------------------------
  reg [81:0] arch_q;
  reg [63:0] sig_q;
  reg sec_q;
  reg prog_en_q;
  reg erase_busy_q;
  reg [5:0] erase_cnt_q;
  reg [1:0] rd_stage_q;
  reg [31:0] rdata_q;
  wire [31:0] mem_rdata;
  wire [31:0] arch_hi_new;

  wire sync_mode_select;
  wire arch_ctrl_global;
  wire [7:0] arch_ctrl_per_cell;
  wire [7:0] pol;
  assign sync_mode_select = arch_q[`OMC_ARCH_SYNC_MODE];
  assign arch_ctrl_global = arch_q[`OMC_ARCH_GLOBAL];
  assign arch_ctrl_per_cell = arch_q[`OMC_ARCH_CELL_LO+7:`OMC_ARCH_CELL_LO];
  assign pol = arch_q[`OMC_ARCH_POL_LO+7:`OMC_ARCH_POL_LO];

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire csr_sel;
  wire [5:0] row;
  wire [1:0] wsel;
  wire row_array;
  wire wr_go;
  wire prog;
  wire wr_array;
  wire wr_sig;
  wire wr_arch;
  wire wr_sec;
  wire wr_erase;
  wire wr_ctrl;
  wire [3:0] mem_we;
  wire [5:0] mem_addr;

  assign csr_sel = avs_address_i[`OMC_CSR_BIT];
  assign row = avs_address_i[`OMC_ROW_HI:`OMC_ROW_LO];
  assign wsel = avs_address_i[`OMC_WSEL_HI:`OMC_WSEL_LO];
  assign row_array = ~row[5];

  // during a bulk erase every access waits, so nothing races the sweep
  assign avs_waitrequest_o = erase_busy_q | (avs_read_i & (rd_stage_q != `OMC_RD_READY));
  assign wr_go = avs_write_i & ~erase_busy_q;
  assign prog = wr_go & ~csr_sel & prog_en_q;
  assign wr_array = prog & row_array & ~sec_q & ~wsel[1];
  assign wr_sig = prog & (row == `OMC_ROW_SIG) & ~wsel[1];
  assign wr_arch = prog & (row == `OMC_ROW_ARCH) & (wsel != 2'h3);
  assign wr_sec = prog & (row == `OMC_ROW_SEC) & (wsel == 2'h0) &
                  avs_byteenable_i[0] & avs_writedata_i[0];
  assign wr_erase = prog & (row == `OMC_ROW_ERASE);
  assign wr_ctrl = wr_go & csr_sel & (wsel == `OMC_CTRL_WSEL) & avs_byteenable_i[0];
  // rows 33 to 59 and row 62 decode to nothing, so writes there vanish

  // the sweep owns the memory port while it runs
  assign mem_we = erase_busy_q ? 4'hF : (wr_array ? avs_byteenable_i : 4'h0);
  assign mem_addr = erase_busy_q ? erase_cnt_q : {row[4:0], wsel[0]};

  omc_row_mem u_mem (
    .clock_i(clock_i),
    .addr_i(mem_addr),
    .we_i(mem_we),
    .wdata_i(erase_busy_q ? 32'h00000000 : avs_writedata_i),
    .rdata_o(mem_rdata)
  );

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[8*k+:8] = nw[8*k+:8];
        end
      end
    end
  endfunction

  assign arch_hi_new = merge({14'h0000, arch_q[81:64]}, avs_writedata_i, avs_byteenable_i);

  // ---------------------------------------------------------------
  // programming, security and bulk erase
  // ---------------------------------------------------------------
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arch_q <= `OMC_ARCH_RST;
      sig_q <= `OMC_SIG_RST;
      sec_q <= 1'b0;
      prog_en_q <= 1'b0;
      erase_busy_q <= 1'b0;
      erase_cnt_q <= 6'h00;
    end else begin
      if (wr_ctrl) begin
        prog_en_q <= avs_writedata_i[`OMC_CTRL_PROG_EN];
      end
      if (erase_busy_q) begin
        erase_cnt_q <= erase_cnt_q + 6'h01;
        if (erase_cnt_q == `OMC_MEM_LAST) begin
          erase_busy_q <= 1'b0;
        end
      end
      if (wr_erase) begin
        // security clears here, alongside the array sweep, and at reset, which keeps the array
        arch_q <= `OMC_ARCH_RST;
        sig_q <= `OMC_SIG_RST;
        sec_q <= 1'b0;
        erase_busy_q <= 1'b1;
        erase_cnt_q <= 6'h00;
      end else begin
        if (wr_sec) begin
          sec_q <= 1'b1;
        end
        if (wr_sig && !wsel[0]) begin
          sig_q[31:0] <= merge(sig_q[31:0], avs_writedata_i, avs_byteenable_i);
        end
        if (wr_sig && wsel[0]) begin
          sig_q[63:32] <= merge(sig_q[63:32], avs_writedata_i, avs_byteenable_i);
        end
        if (wr_arch && (wsel == 2'h0)) begin
          arch_q[31:0] <= merge(arch_q[31:0], avs_writedata_i, avs_byteenable_i);
        end
        if (wr_arch && (wsel == 2'h1)) begin
          arch_q[63:32] <= merge(arch_q[63:32], avs_writedata_i, avs_byteenable_i);
        end
        if (wr_arch && (wsel == 2'h2)) begin
          arch_q[81:64] <= arch_hi_new[17:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // macrocells and preload chain
  // ---------------------------------------------------------------
  wire preload;
  wire clk_en;
  wire shift_en;
  wire shared_oe;
  wire [7:0] cell_q;
  wire [7:0] cell_reg;
  wire [7:0] cell_drive;
  wire [7:0] cell_oe;
  wire [7:0] cell_fb;
  wire [8:0] chain;

  assign preload = s_preload_pin;
  // the array clock pin only clocks registers while sync_mode_select is clear and preload is off
  assign clk_en = ~sync_mode_select & ~preload & s_array_clock & ~clk_prev_q;
  assign shift_en = preload & s_shift_clock & ~shift_clock_prev_q;
  assign shared_oe = ~s_oe_n;
  assign chain[0] = s_serial_in;

  genvar i;
  generate
    for (i = 0; i < `OMC_CELLS; i = i + 1) begin : g_cell
      // outer cells see the synchronous-mode bit in place of the global bit
      wire global_eff;
      if ((i == 0) || (i == `OMC_CELLS - 1)) begin : g_outer
        assign global_eff = sync_mode_select;
      end else begin : g_inner
        assign global_eff = arch_ctrl_global;
      end
      // a combinational cell passes the chain straight through
      assign chain[i+1] = cell_reg[i] ? cell_q[i] : chain[i];
      omc_macrocell u_cell (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .sync_mode_select_i(sync_mode_select),
        .arch_ctrl_global_i(global_eff),
        .arch_ctrl_per_cell_i(arch_ctrl_per_cell[i]),
        .pol_i(pol[i]),
        .sum_i(sum_term_i[i]),
        .pterm_oe_i(pterm_oe_i[i]),
        .shared_oe_i(shared_oe),
        .clk_en_i(clk_en),
        .preload_i(preload),
        .shift_en_i(shift_en),
        .chain_i(chain[i]),
        .pin_i(s_io[i]),
        .q_o(cell_q[i]),
        .registered_o(cell_reg[i]),
        .drive_o(cell_drive[i]),
        .oe_o(cell_oe[i]),
        .feedback_o(cell_fb[i])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  reg [7:0] io_out_q;
  reg [7:0] io_oe_q;
  reg [7:0] fb_q;
  reg clock_data_q;
  reg oe_data_q;
  reg serial_out_oe_q;

  // pins are retimed once; costs a cycle but keeps every pin glitch free
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_out_q <= 8'h00;
      io_oe_q <= 8'h00;
      fb_q <= 8'h00;
      clock_data_q <= 1'b0;
      oe_data_q <= 1'b0;
      serial_out_oe_q <= 1'b0;
    end else begin
      io_out_q <= cell_drive;
      io_oe_q <= cell_oe;
      fb_q <= cell_fb;
      clock_data_q <= sync_mode_select & s_array_clock;
      oe_data_q <= sync_mode_select & ~s_oe_n;
      serial_out_oe_q <= preload & ~chain[`OMC_CELLS];
    end
  end

  assign io_out_o = io_out_q;
  assign io_oe_o = io_oe_q;
  assign feedback_o = fb_q;
  assign clock_pin_data_o = clock_data_q;
  assign oe_pin_data_o = oe_data_q;
  // open drain: only ever pulls low
  assign serial_preload_out_o = 1'b0;
  assign serial_preload_out_oe_o = serial_out_oe_q;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  reg [31:0] rd_mux;
  wire [31:0] status_word;

  assign status_word = {8'h00, cell_q, cell_reg, 4'h0, sync_mode_select, preload, erase_busy_q,
                        sec_q};

  always @* begin
    rd_mux = 32'h00000000;
    if (csr_sel) begin
      if (wsel == `OMC_CTRL_WSEL) begin
        rd_mux = {31'h00000000, prog_en_q};
      end else if (wsel == `OMC_STATUS_WSEL) begin
        rd_mux = status_word;
      end
    end else if (row_array) begin
      if (!sec_q && !wsel[1]) begin
        rd_mux = mem_rdata;
      end
    end else if (row == `OMC_ROW_SIG) begin
      // signature ignores the security cell
      rd_mux = wsel[1] ? 32'h00000000 : (wsel[0] ? sig_q[63:32] : sig_q[31:0]);
    end else if (row == `OMC_ROW_ARCH) begin
      case (wsel)
        2'h0: rd_mux = arch_q[31:0];
        2'h1: rd_mux = arch_q[63:32];
        2'h2: rd_mux = {14'h0000, arch_q[81:64]};
        default: rd_mux = 32'h00000000;
      endcase
    end else if (row == `OMC_ROW_SEC) begin
      rd_mux = {31'h00000000, sec_q};
    end
    // reserved rows fall out as zero
  end

  // stage 0: address the memory, 1: capture, 2: answer
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_stage_q <= 2'h0;
      rdata_q <= 32'h00000000;
    end else if (avs_read_i && !erase_busy_q) begin
      case (rd_stage_q)
        2'h0: rd_stage_q <= 2'h1;
        2'h1: begin
          rd_stage_q <= `OMC_RD_READY;
          rdata_q <= rd_mux;
        end
        default: rd_stage_q <= 2'h0;
      endcase
    end else begin
      rd_stage_q <= 2'h0;
    end
  end

  assign avs_readdata_o = rdata_q;

endmodule
`default_nettype wire

// ==== verif/omc_properties.sv ====
// port checker for the output macrocell block
`timescale 1ns/100ps
`default_nettype none
module omc_properties (
  input wire clock_i,
  input wire nrst_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire array_clock_pin_i,
  input wire shared_oe_n_pin_i,
  input wire clock_pin_data_o,
  input wire oe_pin_data_o,
  input wire [7:0] io_oe_o,
  input wire preload_enable_pin_i,
  input wire serial_preload_out_o,
  input wire serial_preload_out_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  read_stall_a: assert property (avs_read_i && !avs_waitrequest_o |-> $past(avs_waitrequest_o))
    else $error("read finished without a wait cycle");
  read_bound_a: assert property ($rose(avs_read_i) |-> ##[2:80] !avs_waitrequest_o)
    else $error("read not answered in time");
  write_bound_a: assert property ($rose(avs_write_i) |-> ##[0:80] !avs_waitrequest_o)
    else $error("write not answered in time");
  rdata_hold_a: assert property (!$stable(avs_readdata_o) |-> avs_read_i && !avs_waitrequest_o)
    else $error("read data moved outside a read");
  reset_off_a: assert property ($rose(nrst_i) |-> io_oe_o == 8'h00 && !serial_preload_out_oe_o)
    else $error("outputs driven after reset");
  clk_sync_a: assert property ($rose(clock_pin_data_o) |-> $past(array_clock_pin_i, 3))
    else $error("clock pin data rose without the pin");
  oe_sync_a: assert property ($rose(oe_pin_data_o) |-> !$past(shared_oe_n_pin_i, 3))
    else $error("enable pin data rose without the pin");
  serial_low_a: assert property (!serial_preload_out_o)
    else $error("serial out drives high");
  serial_gate_a: assert property (serial_preload_out_oe_o |->
    $past(preload_enable_pin_i, 2) || $past(preload_enable_pin_i, 3))
    else $error("serial out enabled outside preload");
  cover property (avs_read_i && !avs_waitrequest_o);
  cover property (serial_preload_out_oe_o);
  cover property ($rose(clock_pin_data_o));
endmodule
bind omc_top omc_properties u_props (.clock_i(clock_i), .nrst_i(nrst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .array_clock_pin_i(array_clock_pin_i),
  .shared_oe_n_pin_i(shared_oe_n_pin_i), .clock_pin_data_o(clock_pin_data_o),
  .oe_pin_data_o(oe_pin_data_o), .io_oe_o(io_oe_o), .preload_enable_pin_i(preload_enable_pin_i),
  .serial_preload_out_o(serial_preload_out_o), .serial_preload_out_oe_o(serial_preload_out_oe_o));
`default_nettype wire

// ==== verif/omc_tester.sv ====
// board and tester model: array clock, shared enable and preload pins
`timescale 1ns/100ps
`default_nettype none
module omc_tester (
  input wire clock_i,
  input wire serial_out_oe_i,
  output logic array_clock_pin_o,
  output logic shared_oe_n_o,
  output logic preload_en_o,
  output logic serial_in_o,
  output logic shift_clock_o,
  output wire serial_out_line_o
);
  // open drain serial out, pulled up on the board
  assign serial_out_line_o = serial_out_oe_i ? 1'b0 : 1'b1;
  initial begin
    array_clock_pin_o = 1'b0;
    shared_oe_n_o = 1'b0;
    preload_en_o = 1'b0;
    serial_in_o = 1'b1;
    shift_clock_o = 1'b0;
  end
  // pins pass a synchroniser, so every level stands four clocks
  task automatic hold;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic set_array_clock(input logic v);
    array_clock_pin_o <= v;
    hold();
  endtask
  task automatic pulse_array_clock;
    set_array_clock(1'b1);
    set_array_clock(1'b0);
  endtask
  task automatic set_oe_n(input logic v);
    shared_oe_n_o <= v;
    hold();
  endtask
  task automatic set_preload(input logic v);
    preload_en_o <= v;
    hold();
  endtask
  // data settles before the shift clock rises, then is released
  task automatic shift_bit(input logic v);
    serial_in_o <= v;
    hold();
    shift_clock_o <= 1'b1;
    hold();
    shift_clock_o <= 1'b0;
    serial_in_o <= ~v;
    hold();
  endtask
endmodule
`default_nettype wire

// ==== verif/output_macrocell_config_test.sv ====
// self-checking bench for the output macrocell block
`timescale 1ns/100ps
`default_nettype none
module output_macrocell_config_test;
  logic clock_i, nrst_i, rd, wr, wreq, ckd, oed, sdo, sdo_oe;
  logic aclk_pin, oe_n_pin, pre, ser_in, shift_clk, sdo_line;
  logic [3:0] be;
  logic [10:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [7:0] sum, pte, io_in, io_out, io_oe, fb;
  int miscompares, n_tests;
  omc_top DUT (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .array_clock_pin_i(aclk_pin), .shared_oe_n_pin_i(oe_n_pin),
    .clock_pin_data_o(ckd), .oe_pin_data_o(oed), .sum_term_i(sum), .pterm_oe_i(pte),
    .feedback_o(fb), .io_in_i(io_in), .io_out_o(io_out), .io_oe_o(io_oe),
    .preload_enable_pin_i(pre), .serial_preload_in_i(ser_in), .preload_shift_clock_i(shift_clk),
    .serial_preload_out_o(sdo), .serial_preload_out_oe_o(sdo_oe));
  omc_tester tester (.clock_i(clock_i), .serial_out_oe_i(sdo_oe), .array_clock_pin_o(aclk_pin),
    .shared_oe_n_o(oe_n_pin), .preload_en_o(pre), .serial_in_o(ser_in),
    .shift_clock_o(shift_clk), .serial_out_line_o(sdo_line));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // --------------------------------------------------------------
  // bus master: waitrequest and read data are taken at the rising edge
  // --------------------------------------------------------------
  task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (wreq !== 1'b0 && n < 300);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    // one idle edge, so the next call never touches the strobes in this step
    @(posedge clock_i);
    if (n >= 300) begin
      miscompares++;
      results();
    end
  endtask
  task automatic rchk(input logic [10:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q, e);
  endtask
  task automatic arch(input logic s, input logic g, input logic [7:0] c, input logic [7:0] p);
    bus(1'b1, 11'h3C0, {14'h0, s, g, c, p});
    tick(2);
  endtask
  // outer cells take the sync bit in place of the global bit
  function automatic logic cell_oe(input int i, input logic s, input logic g,
    input logic c, input logic pt);
    if (i == 0 || i == 7) g = s;
    case ({s, g, c})
      3'b100: return 1'b1;
      3'b111, 3'b011: return pt;
      3'b010: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic mode_case(input logic s, input logic g, input logic [7:0] c);
    logic [7:0] p, eo, ev, rm;
    p = 8'($urandom);
    arch(s, g, c, p);
    eo = 8'($urandom);
    ev = 8'($urandom);
    sum <= ev;
    pte <= eo;
    io_in <= 8'($urandom);
    tester.set_array_clock(1'b1);
    check(ckd, s);
    check(oed, s);
    for (int i = 0; i < 8; i++) begin
      rm[i] = !s && g && !c[i] && i != 0 && i != 7;
      eo[i] = cell_oe(i, s, g, c[i], eo[i]);
      ev[i] = ev[i] ~^ p[i];
    end
    check(io_oe, eo);
    check(io_out & eo & ~rm, ev & eo & ~rm);
    tester.set_array_clock(1'b0);
  endtask
  initial begin
    logic [7:0] p, e;
    logic [5:0] b;
    logic [31:0] d0, d1;
    {nrst_i, rd, wr, adr, wdat, sum, pte, io_in} = '0;
    be = 4'hF;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(32'h2a95));
    tick(3);
    nrst_i <= 1'b1;
    tick(1);
    bus(1'b1, 11'h400, 32'h1);
    p = 8'($urandom);
    arch(1'b0, 1'b1, 8'h00, p);
    tick(4);
    check(io_out & 8'h7E, 8'h7E);
    check(io_oe, 8'h7E);
    bus(1'b0, 11'h404, 32'h0);
    check(q[15:8], 8'h7E);
    repeat (4) begin
      e = 8'($urandom);
      sum <= e;
      tester.pulse_array_clock();
      check(io_out & 8'h7E, (e ~^ p) & 8'h7E);
    end
    tester.set_oe_n(1'b1);
    check(io_oe, 8'h00);
    tester.set_oe_n(1'b0);
    // --------------------------------------------------------------
    // preload: six registered cells, so six bits fill the chain
    // --------------------------------------------------------------
    tester.set_preload(1'b1);
    bus(1'b0, 11'h404, 32'h0);
    check(q[2], 1'b1);
    b = 6'($urandom);
    for (int k = 0; k < 6; k++) tester.shift_bit(b[k]);
    sum <= ~sum;
    tester.pulse_array_clock();
    e = 8'h00;
    for (int j = 1; j < 7; j++) e[j] = b[6 - j];
    check(fb & 8'h7E, e);
    check(io_out & 8'h7E, ~e & 8'h7E);
    check(sdo_line, b[0]);
    tester.set_preload(1'b0);
    check(sdo_line, 1'b1);
    mode_case(1'b1, 1'b0, 8'h00);
    mode_case(1'b1, 1'b0, 8'hFF);
    mode_case(1'b1, 1'b1, 8'hFF);
    mode_case(1'b0, 1'b1, 8'hFF);
    repeat (3) mode_case(1'b1, 1'b0, 8'($urandom));
    repeat (3) mode_case(1'b0, 1'b1, 8'($urandom));
    // --------------------------------------------------------------
    // row map, security cell and bulk erase
    // --------------------------------------------------------------
    d0 = $urandom;
    d1 = $urandom;
    bus(1'b1, 11'h050, d0);
    bus(1'b1, 11'h1F4, d1);
    rchk(11'h050, d0);
    rchk(11'h1F4, d1);
    // lane write: only byte lanes 0 and 2 take the new word
    bus(1'b1, 11'h054, d0);
    be <= 4'h5;
    bus(1'b1, 11'h054, d1);
    be <= 4'hF;
    rchk(11'h054, (d1 & 32'h00FF00FF) | (d0 & 32'hFF00FF00));
    bus(1'b1, 11'h204, d1);
    bus(1'b1, 11'h210, d0);
    bus(1'b1, 11'h3B0, d0);
    rchk(11'h210, 32'h0);
    rchk(11'h3B0, 32'h0);
    bus(1'b1, 11'h3C8, d0);
    rchk(11'h3C8, d0 & 32'h3FFFF);
    bus(1'b1, 11'h3D0, 32'h1);
    bus(1'b0, 11'h404, 32'h0);
    check(q[0], 1'b1);
    bus(1'b1, 11'h050, d1);
    rchk(11'h050, 32'h0);
    rchk(11'h204, d1);
    bus(1'b1, 11'h3F0, 32'h0);
    for (int n = 0; n < 100; n++) begin
      bus(1'b0, 11'h404, 32'h0);
      if (q[1] === 1'b0) break;
    end
    check(q[1:0], 2'b00);
    rchk(11'h204, 32'h0);
    rchk(11'h3C0, 32'h0);
    rchk(11'h050, 32'h0);
    tick(4);
    check(io_oe, 8'h00);
    results();
  end
endmodule
`default_nettype wire
